// ---- src/qdu_pkg.sv ----
/*
 * shared constants, field layouts and types of the quad converter register bank.
 * assumes a single clk domain for the bank and an sclk-clocked serial front end.
 */
package qdu_pkg;
	localparam int CHANS = 4;
	localparam int WORD_BITS = 24;
	localparam int PEC_BITS = 8;
	localparam int PAYLOAD_W = 13;
	// register select codes
	localparam logic [2:0] SEL_DATA = 3'h0;
	localparam logic [2:0] SEL_GAIN = 3'h2;
	localparam logic [2:0] SEL_GAIN_ALL = 3'h3;
	localparam logic [2:0] SEL_OFFS = 3'h4;
	localparam logic [2:0] SEL_OFFS_ALL = 3'h5;
	localparam logic [2:0] SEL_CLEAR = 3'h6;
	localparam logic [2:0] SEL_CTRL = 3'h7;
	// control register select, data bits 15..13, payload in 12..0
	localparam int CTL_SEL_LSB = 13;
	localparam logic [2:0] CTL_SLEW = 3'h0;
	localparam logic [2:0] CTL_MAIN = 3'h1;
	localparam logic [2:0] CTL_SOFT = 3'h2;
	localparam logic [2:0] CTL_DAC = 3'h3;
	localparam logic [2:0] CTL_DCDC = 3'h4;
	// main control fields
	localparam int MAIN_STATUS_RB = 0;
	localparam int MAIN_OUTEN_ALL = 1;
	localparam int MAIN_DCDC_ALL = 2;
	localparam int MAIN_WD_EN = 3;
	localparam int MAIN_WD_SEL_LSB = 4;
	localparam int MAIN_PEC_EN = 6;
	// channel control fields
	localparam int DCTL_RANGE_LSB = 0;
	localparam int DCTL_EXT_SENSE = 3;
	localparam int DCTL_CLR_EN = 4;
	localparam int DCTL_OUTEN = 5;
	localparam int DCTL_DCDC = 6;
	// supply control fields
	localparam int DCDC_MAXV_LSB = 0;
	localparam int DCDC_PHASE_LSB = 2;
	localparam int DCDC_FREQ_LSB = 4;
	localparam logic [12:0] SW_RESET_VAL = 13'h1555;
	// reset values
	localparam logic [15:0] RST_CODE = 16'h0000;
	localparam logic [12:0] RST_CTL = 13'h0000;
	// watchdog base timeout, doubled per select step
	localparam int CLK_MHZ = 125;
	localparam int WD_BASE_MS = 5;
	localparam int WD_BASE_CYCLES = WD_BASE_MS * 1000 * CLK_MHZ;

	typedef logic [15:0] qdu_code_t;
	typedef logic [PAYLOAD_W-1:0] qdu_payload_t;
	typedef struct packed {
		logic rw;
		logic [1:0] dev;
		logic [2:0] sel;
		logic [1:0] ch;
		qdu_code_t data;
	} qdu_word_t;
	typedef struct packed {
		qdu_word_t word;
		logic word_pend;
		logic tog_meta;
		logic tog_s;
		logic tog_seen;
		logic sync_meta;
		logic sync_s;
		logic load_meta;
		logic load_s;
		logic load_prev;
		logic clr_meta;
		logic clr_s;
		logic [1:0] addr_meta;
		logic [1:0] addr_s;
		qdu_code_t [CHANS-1:0] code;
		qdu_code_t [CHANS-1:0] pend;
		qdu_code_t [CHANS-1:0] active;
		qdu_code_t [CHANS-1:0] gain;
		qdu_code_t [CHANS-1:0] offs;
		qdu_code_t [CHANS-1:0] clrv;
		qdu_payload_t [CHANS-1:0] dctl;
		qdu_payload_t [CHANS-1:0] slew;
		qdu_payload_t main;
		qdu_payload_t dcdc;
		logic [CHANS-1:0] first_seen;
		logic [31:0] wd_cnt;
		logic wd_alarm;
		logic rst_pend;
	} qdu_state_t;
	localparam qdu_state_t ST_RESET = '0;
endpackage

// ---- src/qdu_regs.sv ----
/*
 * serial-fed register bank and output update control for four channels.
 * assumes sclk stops outside frames, sync_n frames each word, and the control
 * pins are asynchronous to clk.
 */
`timescale 1ns/10ps
module qdu_regs
#(
	parameter int CODE_BITS = 16,
	parameter int unsigned WD_BASE_CYCLES = qdu_pkg::WD_BASE_CYCLES
)
(
	// system
	input wire logic clk,
	input wire logic reset,
	// serial link
	input wire logic sclk,
	input wire logic sync_n,
	input wire logic sdin,
	// control pins
	input wire logic load_strobe_n,
	input wire logic clear_n,
	input wire logic [1:0] hw_address_pin,
	// channel registers
	output qdu_pkg::qdu_code_t [qdu_pkg::CHANS-1:0] channel_code,
	output qdu_pkg::qdu_code_t [qdu_pkg::CHANS-1:0] active_code,
	output qdu_pkg::qdu_code_t [qdu_pkg::CHANS-1:0] channel_gain_trim,
	output qdu_pkg::qdu_code_t [qdu_pkg::CHANS-1:0] channel_offset_trim,
	output qdu_pkg::qdu_code_t [qdu_pkg::CHANS-1:0] channel_clear_value,
	output qdu_pkg::qdu_payload_t [qdu_pkg::CHANS-1:0] channel_ctrl,
	output qdu_pkg::qdu_payload_t [qdu_pkg::CHANS-1:0] slew_ctrl,
	// shared control
	output qdu_pkg::qdu_payload_t main_ctrl,
	output qdu_pkg::qdu_payload_t dcdc_ctrl,
	output logic [qdu_pkg::CHANS-1:0] out_enable,
	output logic [qdu_pkg::CHANS-1:0] dcdc_power,
	output logic status_readback_en,
	output logic watchdog_alarm
);
	import qdu_pkg::*;

	qdu_state_t s_reg;
	qdu_state_t s_next;
	logic link_rst_reg;
	logic [5:0] bit_cnt;
	logic [WORD_BITS+PEC_BITS-2:0] shift_sr;
	logic pec_meta;
	logic pec_s;
	qdu_word_t cap_word;
	logic cap_tog;
	qdu_word_t w;
	qdu_code_t data_m;
	qdu_payload_t payload;
	logic [2:0] ctl_sel;
	logic load_fall;
	logic do_commit;
	logic hit;
	logic ctl_hit;
	logic kick;
	logic [31:0] wd_limit;
	logic wd_hit;

	// keep only the code bits of the chosen resolution
	function automatic qdu_code_t code_mask(input qdu_code_t d);
		qdu_code_t r;
		r = '0;
		for (int i = 0; i < 16; i++)
		begin
			if (i >= 16 - CODE_BITS)
				r[i] = d[i];
		end
		return r;
	endfunction

	// link reset follows the system reset, registered so it is glitch free
	always_ff @(posedge clk)
	begin
		link_rst_reg <= reset;
	end

	// bit shifter, cleared by the frame's own sync so a stopped sclk is harmless
	always_ff @(negedge sclk or posedge sync_n or posedge link_rst_reg)
	begin
		if (sync_n || link_rst_reg)
		begin
			bit_cnt <= 6'h00;
			shift_sr <= '0;
		end
		else
		begin
			shift_sr <= {shift_sr[WORD_BITS+PEC_BITS-3:0], sdin};
			if (bit_cnt != 6'h3F)
				bit_cnt <= bit_cnt + 6'h01;
		end
	end

	// word capture and toggle event toward clk; check bits are dropped
	always_ff @(negedge sclk or posedge link_rst_reg)
	begin
		if (link_rst_reg)
		begin
			pec_meta <= 1'b0;
			pec_s <= 1'b0;
			cap_word <= '0;
			cap_tog <= 1'b0;
		end
		else
		begin
			pec_meta <= s_reg.main[MAIN_PEC_EN];
			pec_s <= pec_meta;
			if (!pec_s && bit_cnt == 6'(WORD_BITS - 1))
			begin
				cap_word <= {shift_sr[WORD_BITS-2:0], sdin};
				cap_tog <= ~cap_tog;
			end
			if (pec_s && bit_cnt == 6'(WORD_BITS + PEC_BITS - 1))
			begin
				cap_word <= shift_sr[WORD_BITS+PEC_BITS-2:PEC_BITS-1];
				cap_tog <= ~cap_tog;
			end
		end
	end

	// next-state logic of the whole bank
	always_comb
	begin
		qdu_state_t t;
		t = s_reg;
		s_next = s_reg;
		s_next.tog_meta = cap_tog;
		s_next.tog_s = s_reg.tog_meta;
		s_next.sync_meta = sync_n;
		s_next.sync_s = s_reg.sync_meta;
		s_next.load_meta = load_strobe_n;
		s_next.load_s = s_reg.load_meta;
		s_next.load_prev = s_reg.load_s;
		s_next.clr_meta = clear_n;
		s_next.clr_s = s_reg.clr_meta;
		s_next.addr_meta = hw_address_pin;
		s_next.addr_s = s_reg.addr_meta;

		w = s_reg.word;
		data_m = code_mask(w.data);
		payload = w.data[PAYLOAD_W-1:0];
		ctl_sel = w.data[CTL_SEL_LSB+2:CTL_SEL_LSB];
		load_fall = s_reg.load_prev && !s_reg.load_s;
		// a word is acted on only once sync has returned high
		do_commit = s_reg.word_pend && s_reg.sync_s;
		hit = do_commit && !w.rw && (w.dev == s_reg.addr_s);
		ctl_hit = hit && (w.sel == SEL_CTRL);
		kick = ctl_hit && (ctl_sel == CTL_SOFT) && (payload != SW_RESET_VAL);
		wd_limit = WD_BASE_CYCLES << s_reg.main[MAIN_WD_SEL_LSB+1:MAIN_WD_SEL_LSB];

		if (do_commit)
			s_next.word_pend = 1'b0;
		// the captured word is stable for many clk cycles after the toggle
		if (s_reg.tog_s != s_reg.tog_seen)
		begin
			s_next.word = cap_word;
			s_next.word_pend = 1'b1;
			s_next.tog_seen = s_reg.tog_s;
		end

		// simultaneous update, only after sync has gone high
		if (load_fall && s_reg.sync_s)
		begin
			for (int c = 0; c < CHANS; c++)
			begin
				if (s_reg.first_seen[c])
					s_next.active[c] = s_reg.pend[c];
			end
			s_next.first_seen = '0;
		end

		// register routing
		if (hit)
		begin
			case (w.sel)
				SEL_DATA:
				begin
					s_next.code[w.ch] = data_m;
					if (!s_reg.load_s)
						s_next.active[w.ch] = data_m;
					else if (!s_reg.first_seen[w.ch])
					begin
						s_next.pend[w.ch] = data_m;
						s_next.first_seen[w.ch] = 1'b1;
					end
				end
				SEL_GAIN: s_next.gain[w.ch] = data_m;
				SEL_GAIN_ALL:
				begin
					for (int c = 0; c < CHANS; c++)
						s_next.gain[c] = data_m;
				end
				SEL_OFFS: s_next.offs[w.ch] = data_m;
				SEL_OFFS_ALL:
				begin
					for (int c = 0; c < CHANS; c++)
						s_next.offs[c] = data_m;
				end
				SEL_CLEAR: s_next.clrv[w.ch] = data_m;
				SEL_CTRL:
				begin
					case (ctl_sel)
						CTL_SLEW: s_next.slew[w.ch] = payload;
						CTL_MAIN: s_next.main = payload;
						CTL_SOFT:
						begin
							if (payload == SW_RESET_VAL)
								s_next.rst_pend = 1'b1;
						end
						CTL_DAC: s_next.dctl[w.ch] = payload;
						CTL_DCDC: s_next.dcdc = payload;
						default: s_next.rst_pend = s_reg.rst_pend;
					endcase
				end
				default: s_next.word_pend = s_next.word_pend;
			endcase
		end

		// clear input holds enabled channels at their clear code
		if (!s_reg.clr_s)
		begin
			for (int c = 0; c < CHANS; c++)
			begin
				if (s_reg.dctl[c][DCTL_CLR_EN])
					s_next.active[c] = s_reg.clrv[c];
			end
		end

		// watchdog; the counter parks at its limit, so the timeout only counts as an
		// event while the alarm is clear, otherwise no kick could ever clear it;
		// a timeout in the same cycle as a kick still raises the alarm
		wd_hit = s_reg.main[MAIN_WD_EN] && (s_reg.wd_cnt >= wd_limit) && !s_reg.wd_alarm;
		if (!s_reg.main[MAIN_WD_EN] || kick)
			s_next.wd_cnt = 32'h0000_0000;
		else if (s_reg.wd_cnt < wd_limit)
			s_next.wd_cnt = s_reg.wd_cnt + 32'h0000_0001;
		if (kick)
			s_next.wd_alarm = 1'b0;
		if (wd_hit)
			s_next.wd_alarm = 1'b1;

		// hard or software reset; synchronisers keep running
		if (reset || s_reg.rst_pend)
		begin
			t = s_next;
			s_next = ST_RESET;
			s_next.code = {CHANS{RST_CODE}};
			s_next.dctl = {CHANS{RST_CTL}};
			s_next.tog_meta = t.tog_meta;
			s_next.tog_s = t.tog_s;
			s_next.tog_seen = s_reg.tog_s;
			s_next.sync_meta = t.sync_meta;
			s_next.sync_s = t.sync_s;
			s_next.load_meta = t.load_meta;
			s_next.load_s = t.load_s;
			s_next.load_prev = s_reg.load_s;
			s_next.clr_meta = t.clr_meta;
			s_next.clr_s = t.clr_s;
			s_next.addr_meta = t.addr_meta;
			s_next.addr_s = t.addr_s;
		end
	end

	// single state register
	always_ff @(posedge clk)
	begin
		s_reg <= s_next;
	end

	// outputs straight from state
	assign channel_code = s_reg.code;
	assign active_code = s_reg.active;
	assign channel_gain_trim = s_reg.gain;
	assign channel_offset_trim = s_reg.offs;
	assign channel_clear_value = s_reg.clrv;
	assign channel_ctrl = s_reg.dctl;
	assign slew_ctrl = s_reg.slew;
	assign main_ctrl = s_reg.main;
	assign dcdc_ctrl = s_reg.dcdc;
	assign status_readback_en = s_reg.main[MAIN_STATUS_RB];
	assign watchdog_alarm = s_reg.wd_alarm;

	// per-channel enables; the all-channel bits override each channel
	always_comb
	begin
		for (int c = 0; c < CHANS; c++)
		begin
			out_enable[c] = s_reg.dctl[c][DCTL_OUTEN] | s_reg.main[MAIN_OUTEN_ALL];
			dcdc_power[c] = s_reg.dctl[c][DCTL_DCDC] | s_reg.main[MAIN_DCDC_ALL];
		end
	end

	// checks on the clk side; a pending software reset voids the next cycle
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset || s_reg.rst_pend);

	AST_INDIV_UPDATE: assert property (
		(hit && w.sel == SEL_DATA && !s_reg.load_s && s_reg.clr_s)
		|=> s_reg.active[$past(w.ch)] == $past(data_m))
		else $error("individual write did not update the output code");

	AST_FIRST_PENDING: assert property (
		(hit && w.sel == SEL_DATA && s_reg.load_s && !s_reg.first_seen[w.ch])
		|=> s_reg.pend[$past(w.ch)] == $past(data_m) && s_reg.first_seen[$past(w.ch)])
		else $error("first write under high strobe not taken as pending code");

	AST_LATER_KEPT: assert property (
		(hit && w.sel == SEL_DATA && s_reg.load_s && s_reg.first_seen[w.ch] && !load_fall)
		|=> $stable(s_reg.pend) && s_reg.code[$past(w.ch)] == $past(data_m))
		else $error("later write replaced pending code or was not stored");

	AST_SIM_UPDATE: assert property (
		(load_fall && s_reg.sync_s && s_reg.first_seen[0] && s_reg.clr_s && !hit)
		|=> s_reg.active[0] == $past(s_reg.pend[0]))
		else $error("simultaneous update missed channel zero");

	AST_REARM: assert property (
		(load_fall && s_reg.sync_s) |=> s_reg.first_seen == '0)
		else $error("first-write tracking not rearmed");

	AST_CODE_MASK: assert property (
		(s_reg.code[1] & ~code_mask(16'hFFFF)) == 16'h0000)
		else $error("code bits below resolution are set");

	AST_ADDR_MISMATCH: assert property (
		(do_commit && w.dev != s_reg.addr_s && s_reg.clr_s && !load_fall)
		|=> $stable(s_reg.code) && $stable(s_reg.active) && $stable(s_reg.main))
		else $error("frame for another device changed state");

	AST_SOFT_RESET: assert property (
		disable iff (reset)
		(ctl_hit && ctl_sel == CTL_SOFT && payload == SW_RESET_VAL)
		|=> s_reg.rst_pend ##1 (s_reg.main == '0 && s_reg.first_seen == '0 && !s_reg.rst_pend))
		else $error("software reset value did not reset the bank");

	AST_WD_KICK: assert property (
		kick |=> s_reg.wd_cnt == 32'h0000_0000)
		else $error("software write did not restart the watchdog");

	AST_WD_TRIP: assert property (
		$rose(s_reg.wd_alarm) |-> $past(s_reg.wd_cnt) >= $past(wd_limit))
		else $error("watchdog alarm raised before its timeout");

	AST_WORD_ORDER: assert property (
		(s_reg.tog_s != s_reg.tog_seen) |=> s_reg.word_pend && s_reg.word == $past(cap_word))
		else $error("captured frame word not taken over");

	AST_GAIN_ALL: assert property (
		(hit && w.sel == SEL_GAIN_ALL) |=> s_reg.gain == {CHANS{$past(data_m)}})
		else $error("broadcast gain write did not reach every channel");

	AST_SLEW_WRITE: assert property (
		(ctl_hit && ctl_sel == CTL_SLEW) |=> s_reg.slew[$past(w.ch)] == $past(payload))
		else $error("slew control write not stored for its channel");

	AST_CHAN_CTRL: assert property (
		(ctl_hit && ctl_sel == CTL_DAC) |=> s_reg.dctl[$past(w.ch)] == $past(payload))
		else $error("channel control write not stored for its channel");

	AST_SUPPLY_CTRL: assert property (
		(ctl_hit && ctl_sel == CTL_DCDC) |=> s_reg.dcdc == $past(payload))
		else $error("supply control write not stored");

	AST_CLEAR_HOLD: assert property (
		(!s_reg.clr_s && s_reg.dctl[3][DCTL_CLR_EN])
		|=> s_reg.active[3] == $past(s_reg.clrv[3]))
		else $error("cleared channel does not show its clear code");

	AST_WD_STICKY: assert property (
		(s_reg.wd_alarm && !kick) |=> s_reg.wd_alarm)
		else $error("watchdog alarm dropped without a software write");

	COV_INDIV: cover property (hit && w.sel == SEL_DATA && !s_reg.load_s);
	COV_SIM: cover property (load_fall && s_reg.sync_s && s_reg.first_seen != '0);
	COV_SOFT_RESET: cover property (s_reg.rst_pend);
	COV_WD_ALARM: cover property ($rose(s_reg.wd_alarm));
endmodule

// ---- verif/qdu_host_model.sv ----
/*
 * host side of the serial link: frames one word onto sclk, sync_n and sdin.
 * assumes calls come from one process at a time; the link clock is parked
 * high between frames.
 */
`timescale 1ns/10ps
module qdu_host_model
	import qdu_pkg::*;
(
	// serial link
	output logic sclk,
	output logic sync_n,
	output logic sdin
);
	// idle: clock parked, frame closed
	initial
	begin
		sclk = 1'b1;
		sync_n = 1'b1;
		sdin = 1'b0;
	end

	// 160 ns link period; odd start offset keeps it out of phase with clk
	task automatic frame(input qdu_word_t w, input logic packet_error_check, input logic [7:0] chk);
		logic [31:0] bits;
		int n;
		bits = {w, chk};
		n = packet_error_check ? WORD_BITS + PEC_BITS : WORD_BITS;
		#13 sync_n = 1'b0;
		for (int i = 0; i < n; i++)
		begin
			sdin = bits[31-i];
			#80 sclk = 1'b0;
			#80 sclk = 1'b1;
		end
		// released data line no longer shows the last bit
		#40 sdin = ~sdin;
		sync_n = 1'b1;
		#120;
	endtask
endmodule

// ---- verif/tb_quad_dac_update_and_regs.sv ----
/*
 * self-checking bench for the quad converter register bank.
 * assumes qdu_host_model drives the link and a write commits within 12 clk
 * after the frame closes; watchdog base shortened for simulation.
 */
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_quad_dac_update_and_regs;
	import qdu_pkg::*;
	localparam int unsigned WD_CYC = 200;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic load_strobe_n = 1'b0;
	logic clear_n = 1'b1;
	logic [1:0] hw_address_pin = 2'h2;
	logic pec_on = 1'b0;
	logic sclk, sync_n, sdin;
	qdu_code_t [CHANS-1:0] channel_code, active_code, gain, offs, clrv, code12;
	qdu_payload_t [CHANS-1:0] channel_ctrl, slew_ctrl;
	qdu_payload_t main_ctrl, dcdc_ctrl;
	logic [CHANS-1:0] out_enable, dcdc_power;
	logic status_readback_en, watchdog_alarm;
	int error_cnt = 0;
	int samples_checked = 0;

	// 125 MHz system clock
	always #4 clk = ~clk;

	qdu_host_model host (.sclk(sclk), .sync_n(sync_n), .sdin(sdin));

	qdu_regs #(.CODE_BITS(16), .WD_BASE_CYCLES(WD_CYC)) dut (
		.clk(clk), .reset(reset), .sclk(sclk), .sync_n(sync_n), .sdin(sdin),
		.load_strobe_n(load_strobe_n), .clear_n(clear_n), .hw_address_pin(hw_address_pin),
		.channel_code(channel_code), .active_code(active_code), .channel_gain_trim(gain),
		.channel_offset_trim(offs), .channel_clear_value(clrv), .channel_ctrl(channel_ctrl),
		.slew_ctrl(slew_ctrl), .main_ctrl(main_ctrl), .dcdc_ctrl(dcdc_ctrl),
		.out_enable(out_enable), .dcdc_power(dcdc_power),
		.status_readback_en(status_readback_en), .watchdog_alarm(watchdog_alarm));

	// 12-bit variant on the same link, only its data registers watched
	qdu_regs #(.CODE_BITS(12), .WD_BASE_CYCLES(WD_CYC)) dut_12b (
		.clk(clk), .reset(reset), .sclk(sclk), .sync_n(sync_n), .sdin(sdin),
		.load_strobe_n(load_strobe_n), .clear_n(clear_n), .hw_address_pin(hw_address_pin),
		.channel_code(code12), .active_code(), .channel_gain_trim(),
		.channel_offset_trim(), .channel_clear_value(), .channel_ctrl(), .slew_ctrl(),
		.main_ctrl(), .dcdc_ctrl(), .out_enable(), .dcdc_power(),
		.status_readback_en(), .watchdog_alarm());

	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask

	// whole frame, then wait out the sync and commit path
	task automatic send(input qdu_word_t w);
		host.frame(w, pec_on, 8'hA7);
		tick(12);
	endtask

	task automatic wr(input logic [2:0] sel, input logic [1:0] ch, input qdu_code_t d);
		send('{1'b0, hw_address_pin, sel, ch, d});
	endtask

	task automatic ctl(input logic [2:0] cs, input logic [1:0] ch, input qdu_payload_t p);
		wr(SEL_CTRL, ch, {cs, p});
	endtask

	task automatic close_out;
		$display("checks=%0d errors=%0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// hang guard, nearly four times the expected run
	initial
	begin
		#400000;
		error_cnt++;
		close_out();
	end

	initial
	begin
		tick(16);
		reset = 1'b0;
		tick(4);
		`CHK(channel_code, '0)
		`CHK(gain, '0)
		// individual update, strobe low
		wr(SEL_DATA, 2'h1, 16'hA5C3);
		`CHK(active_code[1], 16'hA5C3)
		`CHK(channel_code[1], 16'hA5C3)
		`CHK(code12[1], 16'hA5C0)
		// wrong device select, then a read: both ignored
		send('{1'b0, 2'h1, SEL_DATA, 2'h1, 16'h0F0F});
		send('{1'b1, hw_address_pin, SEL_DATA, 2'h1, 16'h0F0F});
		`CHK(channel_code[1], 16'hA5C3)
		// trims broadcast then single, then a single clear code
		wr(SEL_GAIN_ALL, 2'h0, 16'h8001);
		wr(SEL_GAIN, 2'h2, 16'h7FFE);
		`CHK(gain, {16'h8001, 16'h7FFE, 16'h8001, 16'h8001})
		wr(SEL_OFFS_ALL, 2'h1, 16'h00FF);
		wr(SEL_OFFS, 2'h0, 16'hFF00);
		`CHK(offs, {16'h00FF, 16'h00FF, 16'h00FF, 16'hFF00})
		wr(SEL_CLEAR, 2'h3, 16'h1234);
		`CHK(clrv, {16'h1234, 48'h0})
		// simultaneous update: first write per channel pends
		load_strobe_n = 1'b1;
		tick(4);
		wr(SEL_DATA, 2'h0, 16'h1111);
		wr(SEL_DATA, 2'h0, 16'h2222);
		wr(SEL_DATA, 2'h2, 16'h3333);
		`CHK(channel_code[0], 16'h2222)
		`CHK(active_code[0], 16'h0000)
		load_strobe_n = 1'b0;
		tick(8);
		`CHK(active_code, {16'h0000, 16'h3333, 16'hA5C3, 16'h1111})
		// rearmed: next strobe cycle takes the new first write
		load_strobe_n = 1'b1;
		tick(4);
		wr(SEL_DATA, 2'h0, 16'h4444);
		wr(SEL_DATA, 2'h0, 16'h5555);
		load_strobe_n = 1'b0;
		tick(8);
		`CHK(active_code[0], 16'h4444)
		// control registers
		ctl(CTL_DAC, 2'h1, 13'h006D);
		`CHK(channel_ctrl[1], 13'h006D)
		`CHK(out_enable, 4'h2)
		`CHK(dcdc_power, 4'h2)
		ctl(CTL_SLEW, 2'h2, 13'h0ABC);
		`CHK(slew_ctrl[2], 13'h0ABC)
		ctl(CTL_DCDC, 2'h0, 13'h003F);
		`CHK(dcdc_ctrl, 13'h003F)
		ctl(CTL_MAIN, 2'h0, 13'h0007);
		`CHK(status_readback_en, 1'b1)
		`CHK(out_enable, 4'hF)
		`CHK(dcdc_power, 4'hF)
		// clear input only on channels that opted in
		ctl(CTL_DAC, 2'h3, 13'h0010);
		clear_n = 1'b0;
		tick(6);
		`CHK(active_code[3], 16'h1234)
		`CHK(active_code[2], 16'h3333)
		clear_n = 1'b1;
		tick(6);
		// packet check on: 32-bit frames, short frames dropped
		ctl(CTL_MAIN, 2'h0, 13'h0047);
		pec_on = 1'b1;
		wr(SEL_DATA, 2'h3, 16'h9ABC);
		`CHK(channel_code[3], 16'h9ABC)
		pec_on = 1'b0;
		wr(SEL_DATA, 2'h3, 16'h0001);
		`CHK(channel_code[3], 16'h9ABC)
		pec_on = 1'b1;
		ctl(CTL_MAIN, 2'h0, 13'h0018);
		pec_on = 1'b0;
		// watchdog at select one: twice the base, so quiet past the base span
		tick(300);
		`CHK(watchdog_alarm, 1'b0)
		tick(100);
		`CHK(watchdog_alarm, 1'b1)
		ctl(CTL_SOFT, 2'h0, 13'h0AAA);
		`CHK(watchdog_alarm, 1'b0)
		// software reset returns every register to zero
		ctl(CTL_SOFT, 2'h0, SW_RESET_VAL);
		`CHK(channel_code, '0)
		`CHK(main_ctrl, 13'h0000)
		wr(SEL_DATA, 2'h0, 16'hBEEF);
		`CHK(active_code[0], 16'hBEEF)
		close_out();
	end
endmodule
